//--- pkg/cmov_pkg.sv
// package for the conditional move decoder: opcodes, flag positions, types
// assumes a 32-bit register file of eight entries and an x86 flag word
package cmov_pkg;

   // ************************************************
   // opcode bytes
   // ************************************************
   localparam logic [7:0] ESCAPE_BYTE    = 8'h0F;
   localparam logic [7:0] OP_IF_OVERFLOW = 8'h40;
   localparam logic [7:0] OP_IF_NO_OVF   = 8'h41;
   localparam logic [7:0] OP_IF_SIGN     = 8'h48;
   localparam logic [7:0] OP_IF_NOT_SIGN = 8'h49;
   localparam logic [7:0] OP_IF_PARITY   = 8'h4A;
   localparam logic [7:0] OP_IF_GE       = 8'h4D;

   // ************************************************
   // flag positions, reset values, timing
   // ************************************************
   localparam int         FLAG_PARITY_BIT   = 2;
   localparam int         FLAG_SIGN_BIT     = 7;
   localparam int         FLAG_OVERFLOW_BIT = 11;
   localparam logic [31:0] FLAGS_RESET      = 32'h0000_0002;
   localparam logic [31:0] REG_RESET        = 32'h0000_0000;
   localparam int         EXEC_CLOCKS       = 1;
   localparam logic [1:0] MOD_REGISTER      = 2'h3;

   // ************************************************
   // types
   // ************************************************
   typedef enum logic [2:0] {
      MOVE_IF_OVERFLOW,
      MOVE_IF_NO_OVERFLOW,
      MOVE_IF_SIGN,
      MOVE_IF_NOT_SIGN,
      MOVE_IF_PARITY_EVEN,
      MOVE_IF_GE
   } move_kind_t;

   typedef struct packed {
      logic [1:0] mode;
      logic [2:0] dest;
      logic [2:0] rm;
   } operand_byte_t;

   typedef struct packed {
      logic       valid;
      logic       taken;
      logic [2:0] dest;
      logic [31:0] value;
   } writeback_t;

endpackage : cmov_pkg

//--- rtl/conditional_move_decode.sv
// conditional move decoder and executor for the integer core
// assumes fetch presents one byte per cycle with a valid strobe, and that a
// memory operand is returned by the load path on mem_valid after mem_req
//
// Functional notes
// [RULE_01] 0F 4D modrm: move if greater-or-equal, 1 clock
// [RULE_02] 0F 40 modrm: move if overflow, 1 clock
// [RULE_03] 0F 41 modrm: move if overflow clear, 1 clock
// [RULE_04] 0F 4A modrm: move if parity set, 1 clock
// [RULE_05] 0F 48/49: move on sign set/clear
// [RULE_06] false condition keeps destination; memory still addressed
`timescale 1ns/100ps

module conditional_move_decode
   import cmov_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // fetch stream
   input  wire logic        fetch_valid,
   input  wire logic [7:0]  fetch_byte,
   output logic             fetch_ready,
   // flag word from the core, never written here
   input  wire logic [31:0] flags,
   // memory operand path
   output logic             mem_req,
   output logic [2:0]       mem_base,
   input  wire logic        mem_valid,
   input  wire logic [31:0] mem_data,
   // register file view
   input  wire logic [2:0]  read_index,
   output logic [31:0]      read_data,
   // completed instruction report
   output writeback_t       retire,
   output logic             unknown_opcode
);

   // ************************************************
   // decode helpers
   // ************************************************
   function automatic logic cond_true(input move_kind_t k, input logic [31:0] f);
      logic ovf;
      logic sgn;
      ovf = f[FLAG_OVERFLOW_BIT];
      sgn = f[FLAG_SIGN_BIT];
      case (k)
         MOVE_IF_OVERFLOW:    cond_true = ovf;                  // RULE_02
         MOVE_IF_NO_OVERFLOW: cond_true = !ovf;                 // RULE_03
         MOVE_IF_SIGN:        cond_true = sgn;                  // RULE_05
         MOVE_IF_NOT_SIGN:    cond_true = !sgn;                 // RULE_05
         MOVE_IF_PARITY_EVEN: cond_true = f[FLAG_PARITY_BIT];   // RULE_04
         MOVE_IF_GE:          cond_true = (sgn == ovf);         // RULE_01
         default:             cond_true = 1'b0;
      endcase
   endfunction : cond_true

   function automatic logic known_op(input logic [7:0] b);
      known_op = (b == OP_IF_OVERFLOW) || (b == OP_IF_NO_OVF) || (b == OP_IF_SIGN) ||
                 (b == OP_IF_NOT_SIGN) || (b == OP_IF_PARITY) || (b == OP_IF_GE);
   endfunction : known_op

   function automatic move_kind_t kind_of(input logic [7:0] b);
      case (b)
         OP_IF_OVERFLOW: kind_of = MOVE_IF_OVERFLOW;       // RULE_02
         OP_IF_NO_OVF:   kind_of = MOVE_IF_NO_OVERFLOW;    // RULE_03
         OP_IF_SIGN:     kind_of = MOVE_IF_SIGN;           // RULE_05
         OP_IF_NOT_SIGN: kind_of = MOVE_IF_NOT_SIGN;       // RULE_05
         OP_IF_PARITY:   kind_of = MOVE_IF_PARITY_EVEN;    // RULE_04
         default:        kind_of = MOVE_IF_GE;             // RULE_01
      endcase
   endfunction : kind_of

   // ************************************************
   // decode state
   // ************************************************
   typedef enum logic [1:0] {WAIT_ESCAPE, WAIT_OPCODE, WAIT_OPERAND, WAIT_MEMORY} phase_t;

   phase_t        phase_q, phase_d;
   move_kind_t    kind_q, kind_d;
   operand_byte_t opnd_q, opnd_d;
   logic [31:0]   regs_q [8];
   logic [31:0]   regs_d [8];
   writeback_t    retire_q, retire_d;
   logic          unknown_q, unknown_d;
   operand_byte_t in_opnd;

   assign in_opnd     = operand_byte_t'(fetch_byte);
   // stall fetch while a memory operand is outstanding
   assign fetch_ready = (phase_q != WAIT_MEMORY);
   assign mem_req     = (phase_q == WAIT_MEMORY);
   assign mem_base    = opnd_q.rm;
   assign read_data   = regs_q[read_index];
   assign retire      = retire_q;
   assign unknown_opcode = unknown_q;

   // next state: escape, opcode, operand, optional memory wait
   always_comb begin
      phase_d   = phase_q;
      kind_d    = kind_q;
      opnd_d    = opnd_q;
      regs_d    = regs_q;
      retire_d  = '0;
      unknown_d = 1'b0;
      case (phase_q)
         WAIT_ESCAPE: begin
            if (fetch_valid && fetch_byte == ESCAPE_BYTE) begin
               phase_d = WAIT_OPCODE;
            end
         end
         WAIT_OPCODE: begin
            if (fetch_valid) begin
               if (known_op(fetch_byte)) begin
                  kind_d  = kind_of(fetch_byte);
                  phase_d = WAIT_OPERAND;
               end else begin
                  unknown_d = 1'b1;
                  phase_d   = WAIT_ESCAPE;
               end
            end
         end
         WAIT_OPERAND: begin
            if (fetch_valid) begin
               opnd_d = in_opnd;
               if (in_opnd.mode == MOD_REGISTER) begin
                  // register source completes in the operand cycle
                  retire_d.valid = 1'b1;
                  retire_d.dest  = in_opnd.dest;
                  retire_d.value = regs_q[in_opnd.rm];
                  retire_d.taken = cond_true(kind_q, flags);             // RULE_01
                  if (retire_d.taken) begin
                     regs_d[in_opnd.dest] = regs_q[in_opnd.rm];
                  end
                  phase_d = WAIT_ESCAPE;
               end else begin
                  // memory source is fetched even if the move will not happen
                  phase_d = WAIT_MEMORY;                                   // RULE_06
               end
            end
         end
         WAIT_MEMORY: begin
            if (mem_valid) begin
               retire_d.valid = 1'b1;
               retire_d.dest  = opnd_q.dest;
               retire_d.value = mem_data;
               retire_d.taken = cond_true(kind_q, flags);
               if (retire_d.taken) begin
                  regs_d[opnd_q.dest] = mem_data;                          // RULE_06
               end
               phase_d = WAIT_ESCAPE;
            end
         end
         default: phase_d = WAIT_ESCAPE;
      endcase
   end

   // registers only; flags are input and never written back
   always_ff @(posedge clock) begin
      if (reset) begin
         phase_q   <= WAIT_ESCAPE;
         kind_q    <= MOVE_IF_GE;
         opnd_q    <= '0;
         retire_q  <= '0;
         unknown_q <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            regs_q[i] <= REG_RESET;
         end
      end else begin
         phase_q   <= phase_d;
         kind_q    <= kind_d;
         opnd_q    <= opnd_d;
         retire_q  <= retire_d;
         unknown_q <= unknown_d;
         regs_q    <= regs_d;
      end
   end

   // ************************************************
   // assertions
   // ************************************************
   sequence s_reg_operand;
      phase_q == WAIT_OPERAND && fetch_valid && in_opnd.mode == MOD_REGISTER;
   endsequence

   a_reg_retire_one: assert property (@(posedge clock) disable iff (reset) // RULE_01
      s_reg_operand |=> retire_q.valid)
      else $error("register form did not retire in one clock");

   a_false_keeps_dest: assert property (@(posedge clock) disable iff (reset) // RULE_06
      (retire_q.valid && !retire_q.taken) |-> regs_q[retire_q.dest] == $past(regs_q[retire_d.dest]))
      else $error("destination changed on false condition");

   a_taken_writes: assert property (@(posedge clock) disable iff (reset) // RULE_02
      (retire_q.valid && retire_q.taken) |-> regs_q[retire_q.dest] == retire_q.value)
      else $error("taken move did not write destination");

   a_overflow_cond: assert property (@(posedge clock) disable iff (reset) // RULE_02
      (s_reg_operand and kind_q == MOVE_IF_OVERFLOW) |=> retire_q.taken == $past(flags[FLAG_OVERFLOW_BIT]))
      else $error("overflow condition wrong");

   a_no_ovf_cond: assert property (@(posedge clock) disable iff (reset) // RULE_03
      (s_reg_operand and kind_q == MOVE_IF_NO_OVERFLOW) |=> retire_q.taken != $past(flags[FLAG_OVERFLOW_BIT]))
      else $error("no-overflow condition wrong");

   a_parity_cond: assert property (@(posedge clock) disable iff (reset) // RULE_04
      (s_reg_operand and kind_q == MOVE_IF_PARITY_EVEN) |=> retire_q.taken == $past(flags[FLAG_PARITY_BIT]))
      else $error("parity condition wrong");

   a_sign_cond: assert property (@(posedge clock) disable iff (reset) // RULE_05
      (s_reg_operand and kind_q == MOVE_IF_SIGN) |=> retire_q.taken == $past(flags[FLAG_SIGN_BIT]))
      else $error("sign condition wrong");

   a_not_sign_cond: assert property (@(posedge clock) disable iff (reset) // RULE_05
      (s_reg_operand and kind_q == MOVE_IF_NOT_SIGN) |=> retire_q.taken != $past(flags[FLAG_SIGN_BIT]))
      else $error("not-sign condition wrong");

   a_ge_cond: assert property (@(posedge clock) disable iff (reset) // RULE_01
      (s_reg_operand and kind_q == MOVE_IF_GE) |=>
         retire_q.taken == ($past(flags[FLAG_SIGN_BIT]) == $past(flags[FLAG_OVERFLOW_BIT])))
      else $error("greater-or-equal condition wrong");

   a_mem_addressed: assert property (@(posedge clock) disable iff (reset) // RULE_06
      (phase_q == WAIT_OPERAND && fetch_valid && in_opnd.mode != MOD_REGISTER) |=> mem_req && !fetch_ready)
      else $error("memory operand not requested");

endmodule : conditional_move_decode

//--- tb/fetch_model.sv
// fetch stage and load path model facing the decoder
// assumes the bench queues bytes and sets the load answer before each run
`timescale 1ns/100ps

module fetch_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // fetch stream
   output logic             fetch_valid = 1'b0,
   output logic [7:0]       fetch_byte = 8'h00,
   input  wire logic        fetch_ready,
   // load path
   input  wire logic        mem_req,
   output logic             mem_valid = 1'b0,
   output logic [31:0]      mem_data = 32'h0000_0000
);
   logic [7:0]  bytes_q[$];
   logic [31:0] load_value = 32'h0000_0000;
   int          load_delay = 0;
   int          wait_cnt = 0;

   // ***********
   // byte stream
   // ***********
   // idle bus toggles so a stale byte never repeats
   always @(posedge clock) begin
      if (fetch_valid && fetch_ready && bytes_q.size() > 0)
         void'(bytes_q.pop_front());
      if (!reset && bytes_q.size() > 0) begin
         fetch_valid <= 1'b1;
         fetch_byte  <= bytes_q[0];
      end else begin
         fetch_valid <= 1'b0;
         fetch_byte  <= ~fetch_byte;
      end
   end

   // *********
   // load path
   // *********
   // one pulse per request, after load_delay idle cycles
   always @(posedge clock) begin
      if (mem_req && !mem_valid && wait_cnt >= load_delay) begin
         mem_valid <= 1'b1;
         mem_data  <= load_value;
         wait_cnt  <= 0;
      end else begin
         mem_valid <= 1'b0;
         mem_data  <= ~mem_data;
         wait_cnt  <= (mem_req && !mem_valid) ? wait_cnt + 1 : 0;
      end
   end
endmodule : fetch_model

//--- tb/tb_conditional_move_decode.sv
// self-checking bench for the conditional move decoder
// assumes fetch_model stands in for fetch and the load path
`timescale 1ns/100ps

module tb_conditional_move_decode
   import cmov_pkg::*;
;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic [31:0] flags = 32'h0;
   logic [2:0]  read_index = 3'h0;
   logic        fetch_valid, fetch_ready, mem_req, mem_valid, unknown_opcode;
   logic [7:0]  fetch_byte;
   logic [2:0]  mem_base;
   logic [31:0] mem_data, read_data;
   writeback_t  retire;
   logic [31:0] regs[8];
   int          n_fail = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          ev_at = 0;

   // *******
   // harness
   // *******
   always #2 clock = ~clock;
   // last byte taken or load answer, for latency
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if ((fetch_valid && fetch_ready) || mem_valid)
         ev_at <= cyc;
   end

   conditional_move_decode u_conditional_move_decode (.clock(clock), .reset(reset),
      .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_ready(fetch_ready), .flags(flags),
      .mem_req(mem_req), .mem_base(mem_base), .mem_valid(mem_valid), .mem_data(mem_data),
      .read_index(read_index), .read_data(read_data), .retire(retire), .unknown_opcode(unknown_opcode));
   fetch_model u_fetch_model (.clock(clock), .reset(reset), .fetch_valid(fetch_valid),
      .fetch_byte(fetch_byte), .fetch_ready(fetch_ready), .mem_req(mem_req), .mem_valid(mem_valid),
      .mem_data(mem_data));

   // *******
   // helpers
   // *******
   task automatic cmp_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_bit
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word
   task automatic check_reg(input logic [2:0] i, input logic [31:0] exp);
      @(posedge clock) read_index <= i;
      @(negedge clock) cmp_word(read_data, exp);
   endtask : check_reg
   function automatic logic cond_of(input logic [7:0] op, input logic [31:0] f);
      case (op)
         OP_IF_OVERFLOW: return f[FLAG_OVERFLOW_BIT];
         OP_IF_NO_OVF:   return !f[FLAG_OVERFLOW_BIT];
         OP_IF_SIGN:     return f[FLAG_SIGN_BIT];
         OP_IF_NOT_SIGN: return !f[FLAG_SIGN_BIT];
         OP_IF_PARITY:   return f[FLAG_PARITY_BIT];
         default:        return f[FLAG_SIGN_BIT] == f[FLAG_OVERFLOW_BIT];
      endcase
   endfunction : cond_of
   // one instruction; memory form when mod is not 3
   task automatic exec(input logic [7:0] op, input logic [7:0] rm, input int dly, input logic [31:0] w);
      logic ok;
      logic mem;
      int   n;
      mem = rm[7:6] != MOD_REGISTER;
      u_fetch_model.load_delay = dly;
      u_fetch_model.load_value = w;
      u_fetch_model.bytes_q.push_back(ESCAPE_BYTE);
      u_fetch_model.bytes_q.push_back(op);
      u_fetch_model.bytes_q.push_back(rm);
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (retire.valid !== 1'b1 && n < 50);
      // flags written on the caller's edge have settled by now
      ok = cond_of(op, flags);
      cmp_bit(retire.valid, 1'b1);
      cmp_word(cyc - ev_at, EXEC_CLOCKS);
      cmp_bit(retire.taken, ok);
      cmp_word({29'h0, retire.dest}, {29'h0, rm[5:3]});
      if (mem)
         cmp_word({29'h0, mem_base}, {29'h0, rm[2:0]});
      // value carries the source even when the move is not taken
      cmp_word(retire.value, mem ? w : regs[rm[2:0]]);
      if (ok)
         regs[rm[5:3]] = mem ? w : regs[rm[2:0]];
      @(negedge clock) cmp_bit(retire.valid, 1'b0);
      check_reg(rm[5:3], regs[rm[5:3]]);
   endtask : exec

   // *********
   // scenarios
   // *********
   task automatic test_reset;
      cmp_bit(fetch_ready, 1'b1);
      cmp_bit(mem_req, 1'b0);
      for (int i = 0; i < 8; i++)
         check_reg(i[2:0], REG_RESET);
      $display("test reset done");
   endtask : test_reset
   // memory loads, slower each time
   task automatic test_load;
      @(posedge clock) flags <= 32'h0;
      for (int r = 0; r < 8; r++)
         exec(OP_IF_NO_OVF, {2'h0, r[2:0], r[2:0]}, r, 32'hC0DE_0000 + r * 32'h111);
      $display("test load done");
   endtask : test_load
   // every kind against five flag patterns, register form
   task automatic test_kinds;
      logic [7:0]  ops[6] = '{OP_IF_GE, OP_IF_OVERFLOW, OP_IF_NO_OVF, OP_IF_PARITY, OP_IF_SIGN, OP_IF_NOT_SIGN};
      logic [31:0] fl[5] = '{32'h0, 32'h800, 32'h80, 32'h880, 32'h4};
      logic [2:0]  d;
      for (int i = 0; i < 6; i++)
         for (int j = 0; j < 5; j++) begin
            d = 3'(i + j);
            @(posedge clock) flags <= fl[j];
            exec(ops[i], {MOD_REGISTER, d, d + 3'h1}, 0, 32'h0);
         end
      $display("test kinds done");
   endtask : test_kinds
   // false condition still fetches the memory operand
   task automatic test_mem_false;
      @(posedge clock) flags <= 32'h800;
      exec(OP_IF_NO_OVF, 8'h55, 3, 32'hDEAD_BEEF);
      $display("test mem false done");
   endtask : test_mem_false
   // junk dropped in idle, bad opcode flagged, then recovery
   task automatic test_unknown;
      int n;
      u_fetch_model.bytes_q = '{8'h4D, ESCAPE_BYTE, 8'h42};
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (unknown_opcode !== 1'b1 && n < 20);
      cmp_bit(unknown_opcode, 1'b1);
      cmp_bit(retire.valid, 1'b0);
      exec(OP_IF_GE, 8'hCA, 0, 32'h0);
      $display("test unknown done");
   endtask : test_unknown

   task automatic test_done;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   // watchdog well beyond the expected few hundred cycles
   initial begin
      #200000;
      n_fail++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++)
         regs[i] = REG_RESET;
      test_reset();
      test_load();
      test_kinds();
      test_mem_false();
      test_unknown();
      test_done();
   end
endmodule : tb_conditional_move_decode
